// ---- pkg/query_host_pkg.sv ----
// Notes on behaviour
// R1: Write 98h at 55h word, AAh byte
// R2: Word mode reads keep A7 upward zero
// R3: Reset command ends query mode
// R4: Query command also accepted from autoselect
// R5: Reset from autoselect-entered query returns autoselect
// R6: Words 10h-12h read 0051h,0052h,0059h
// R7: Words 13h,14h read 0002h,0000h
// R8: Words 15h,16h read 0040h,0000h
// R9: Words 17h-1Ah read 0000h
// R10: Words 1Bh,1Ch read 0017h,0019h
// R11: Words 1Dh,1Eh read 0000h
// R12: Words 1Fh-22h read 3,0,9,0
// R13: Words 23h-26h read 5,0,4,0
// R14: Word 27h reads 0015h
// R15: Words 28h,29h read 0002h,0000h
// R16: Words 2Ah,2Bh read 0000h
// R17: Word 2Ch reads 0002h
// R18: Words 2Dh-30h read 7,0,20h,0
// R19: Words 31h-34h read 1Eh,0,0,1
// R20: Words 35h-3Ch read 0000h
// R21: Byte mode address is word index doubled
// R22: Reset command ignores address bits
// R23: Autoselect needs two unlocks then command
package query_host_pkg;
  localparam int          ADDR_W        = 20;
  localparam int          DATA_W        = 16;
  localparam logic [7:0]  CMD_QUERY     = 8'h98;
  localparam logic [7:0]  CMD_RESET     = 8'hF0;
  localparam logic [7:0]  CMD_UNLOCK1   = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2   = 8'h55;
  localparam logic [7:0]  CMD_AUTOSEL   = 8'h90;
  localparam logic [19:0] ADR_QUERY_W   = 20'h00055;
  localparam logic [19:0] ADR_QUERY_B   = 20'h000AA;
  localparam logic [19:0] ADR_UNLOCK1_W = 20'h00555;
  localparam logic [19:0] ADR_UNLOCK2_W = 20'h002AA;
  localparam logic [19:0] ADR_UNLOCK1_B = 20'h00AAA;
  localparam logic [19:0] ADR_UNLOCK2_B = 20'h00555;
  localparam logic [19:0] ADR_RESET     = 20'h00000;
  localparam logic [5:0]  TBL_FIRST     = 6'h10;
  localparam logic [5:0]  TBL_LAST      = 6'h3C;
  // Bus cycle phase lengths in ns, converted to 8 ns cycles
  localparam int          CLK_NS        = 8;
  localparam int          T_SETUP_NS    = 30;
  localparam int          T_PULSE_NS    = 40;
  localparam int          T_ACC_NS      = 80;
  localparam int          T_HOLD_NS     = 20;
  localparam int          SETUP_CYC     = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PULSE_CYC     = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          ACC_CYC       = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int          HOLD_CYC      = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W         = 5;
endpackage

// ---- hw/query_expect.sv ----
`timescale 1ns/10ps
// Expected query table content by word index
module query_expect (
  input  wire logic [5:0]  idx,
  output logic      [15:0] value,
  output logic             in_table
);
  always_comb begin
    in_table = (idx >= query_host_pkg::TBL_FIRST) && (idx <= query_host_pkg::TBL_LAST);
    case (idx)
      6'h10: value = 16'h0051; // [R6]
      6'h11: value = 16'h0052; // [R6]
      6'h12: value = 16'h0059; // [R6]
      6'h13: value = 16'h0002; // [R7]
      6'h15: value = 16'h0040; // [R8]
      6'h1B: value = 16'h0017; // [R10]
      6'h1C: value = 16'h0019; // [R10]
      6'h1F: value = 16'h0003; // [R12]
      6'h21: value = 16'h0009; // [R12]
      6'h23: value = 16'h0005; // [R13]
      6'h25: value = 16'h0004; // [R13]
      6'h27: value = 16'h0015; // [R14]
      6'h28: value = 16'h0002; // [R15]
      6'h2C: value = 16'h0002; // [R17]
      6'h2D: value = 16'h0007; // [R18]
      6'h2F: value = 16'h0020; // [R18]
      6'h31: value = 16'h001E; // [R19]
      6'h34: value = 16'h0001; // [R19]
      // 14,16,17-1A,1D,1E,20,22,24,26,29-2B,2E,30,32,33,35-3C are zero
      default: value = 16'h0000; // [R7] [R8] [R9] [R11] [R16] [R20]
    endcase
  end
endmodule

// ---- hw/query_host.sv ----
`timescale 1ns/10ps
// Host that walks the flash query table over the parallel bus and checks it
module query_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        byte_mode,
  input  wire logic        via_autosel,
  output logic             busy,
  output logic             done,
  output logic             match,
  output logic      [5:0]  fail_idx,
  output logic      [19:0] flash_addr,
  output logic      [15:0] flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic             flash_byte_n
);
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_WR    = 6'h02,
    S_RD    = 6'h04,
    S_GAP   = 6'h08,
    S_NEXT  = 6'h10,
    S_DONE  = 6'h20
  } st_t;

  typedef enum logic [6:0] {
    P_UNL1 = 7'h01,
    P_UNL2 = 7'h02,
    P_AUTO = 7'h04,
    P_QRY  = 7'h08,
    P_TBL  = 7'h10,
    P_RST  = 7'h20,
    P_RST2 = 7'h40
  } ph_t;

  typedef struct packed {
    st_t         st;
    ph_t         ph;
    logic [4:0]  cnt;
    logic [5:0]  idx;
    logic        bm;
    logic        au;
    logic        busy;
    logic        done;
    logic        match;
    logic [5:0]  fail;
    logic [19:0] addr;
    logic [15:0] dq;
    logic        oe;
    logic        ce_n;
    logic        rd_n;
    logic        we_n;
    logic [2:0]  sync_v;
    logic [15:0] sy1;
    logic [15:0] sy2;
  } state_t;

  state_t s_r, s_nxt;
  logic [15:0] exp_val;
  logic        exp_in;
  logic [5:0]  rd_idx;

  query_expect u_exp (
    .idx      (rd_idx),
    .value    (exp_val),
    .in_table (exp_in)
  );
  assign rd_idx = s_r.idx;

  // Address for a table index: doubled in byte mode, high bits zero
  function automatic logic [19:0] tbl_addr(input logic [5:0] i, input logic bm);
    tbl_addr = bm ? {13'h0000, i, 1'b0} : {14'h0000, i}; // [R21] [R2]
  endfunction

  function automatic logic [19:0] cmd_addr(input ph_t p, input logic bm);
    case (p)
      P_UNL1:  cmd_addr = bm ? query_host_pkg::ADR_UNLOCK1_B : query_host_pkg::ADR_UNLOCK1_W;
      P_UNL2:  cmd_addr = bm ? query_host_pkg::ADR_UNLOCK2_B : query_host_pkg::ADR_UNLOCK2_W;
      P_AUTO:  cmd_addr = bm ? query_host_pkg::ADR_UNLOCK1_B : query_host_pkg::ADR_UNLOCK1_W;
      P_QRY:   cmd_addr = bm ? query_host_pkg::ADR_QUERY_B : query_host_pkg::ADR_QUERY_W; // [R1]
      default: cmd_addr = query_host_pkg::ADR_RESET; // [R22]
    endcase
  endfunction

  function automatic logic [7:0] cmd_data(input ph_t p);
    case (p)
      P_UNL1:  cmd_data = query_host_pkg::CMD_UNLOCK1; // [R23]
      P_UNL2:  cmd_data = query_host_pkg::CMD_UNLOCK2; // [R23]
      P_AUTO:  cmd_data = query_host_pkg::CMD_AUTOSEL; // [R23]
      P_QRY:   cmd_data = query_host_pkg::CMD_QUERY; // [R1] [R4]
      default: cmd_data = query_host_pkg::CMD_RESET; // [R3] [R5]
    endcase
  endfunction

  localparam logic [4:0] C_SETUP = 5'(query_host_pkg::SETUP_CYC);
  localparam logic [4:0] C_PULSE = 5'(query_host_pkg::SETUP_CYC + query_host_pkg::PULSE_CYC);
  localparam logic [4:0] C_ACC   = 5'(query_host_pkg::SETUP_CYC + query_host_pkg::ACC_CYC);
  localparam logic [4:0] C_HOLD  = 5'(query_host_pkg::HOLD_CYC);

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.sync_v = {s_r.sync_v[1:0], 1'b0};
    s_nxt.sy1 = flash_dq_in;
    s_nxt.sy2 = s_r.sy1;
    case (s_r.st)
      S_IDLE: begin
        if (start) begin
          s_nxt.bm    = byte_mode;
          s_nxt.au    = via_autosel;
          s_nxt.ph    = via_autosel ? P_UNL1 : P_QRY; // [R4] [R23]
          s_nxt.idx   = query_host_pkg::TBL_FIRST;
          s_nxt.busy  = 1'b1;
          s_nxt.match = 1'b1;
          s_nxt.fail  = 6'h00;
          s_nxt.cnt   = 5'd0;
          s_nxt.st    = S_WR;
        end
      end
      S_WR: begin
        s_nxt.addr = cmd_addr(s_r.ph, s_r.bm);
        s_nxt.dq   = {8'h00, cmd_data(s_r.ph)};
        s_nxt.oe   = 1'b1;
        s_nxt.ce_n = 1'b0;
        s_nxt.cnt  = s_r.cnt + 5'd1;
        s_nxt.we_n = !(s_r.cnt >= C_SETUP && s_r.cnt < C_PULSE);
        if (s_r.cnt == C_PULSE) begin
          s_nxt.cnt = 5'd0;
          s_nxt.st  = S_GAP;
        end
      end
      S_RD: begin
        s_nxt.addr = tbl_addr(s_r.idx, s_r.bm);
        s_nxt.oe   = 1'b0;
        s_nxt.ce_n = 1'b0;
        s_nxt.rd_n = 1'b0;
        s_nxt.cnt  = s_r.cnt + 5'd1;
        if (s_r.cnt == C_ACC) begin
          s_nxt.sync_v = {s_r.sync_v[1:0], 1'b1};
        end
        if (s_r.sync_v[2]) begin
          // Sample taken two flops after the access window closes
          if (s_r.match && ((s_r.bm ? {8'h00, s_r.sy2[7:0]} : s_r.sy2) != exp_val)) begin
            s_nxt.match = 1'b0;
            s_nxt.fail  = s_r.idx;
          end
          s_nxt.cnt = 5'd0;
          s_nxt.st  = S_GAP;
        end
      end
      S_GAP: begin
        s_nxt.ce_n = 1'b1;
        s_nxt.rd_n = 1'b1;
        s_nxt.we_n = 1'b1;
        s_nxt.oe   = 1'b0;
        s_nxt.cnt  = s_r.cnt + 5'd1;
        if (s_r.cnt == C_HOLD) begin
          s_nxt.cnt = 5'd0;
          s_nxt.st  = S_NEXT;
        end
      end
      S_NEXT: begin
        s_nxt.st = S_WR;
        case (s_r.ph)
          P_UNL1: s_nxt.ph = P_UNL2;
          P_UNL2: s_nxt.ph = P_AUTO;
          P_AUTO: s_nxt.ph = P_QRY;
          P_QRY: begin
            s_nxt.ph = P_TBL;
            s_nxt.st = S_RD;
          end
          P_TBL: begin
            if (exp_in && s_r.idx != query_host_pkg::TBL_LAST) begin
              s_nxt.idx = s_r.idx + 6'd1;
              s_nxt.st  = S_RD;
            end else begin
              s_nxt.ph = P_RST; // [R3]
            end
          end
          P_RST: begin
            // From autoselect a second reset reaches array reads
            if (s_r.au) s_nxt.ph = P_RST2; // [R5]
            else s_nxt.st = S_DONE;
          end
          default: s_nxt.st = S_DONE;
        endcase
      end
      S_DONE: begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st   = S_IDLE;
      end
      default: s_nxt.st = S_IDLE;
    endcase
    if (!rst_n) begin
      s_nxt = '0;
      s_nxt.st    = S_IDLE;
      s_nxt.ph    = P_QRY;
      s_nxt.ce_n  = 1'b1;
      s_nxt.rd_n  = 1'b1;
      s_nxt.we_n  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign busy         = s_r.busy;
  assign done         = s_r.done;
  assign match        = s_r.match;
  assign fail_idx     = s_r.fail;
  assign flash_addr   = s_r.addr;
  assign flash_dq_out = s_r.dq;
  assign flash_dq_oe  = s_r.oe;
  assign flash_ce_n   = s_r.ce_n;
  assign flash_oe_n   = s_r.rd_n;
  assign flash_we_n   = s_r.we_n;
  assign flash_byte_n = !s_r.bm;

  sequence qry_write_s;
    !flash_we_n && flash_dq_out[7:0] == query_host_pkg::CMD_QUERY;
  endsequence

  query_cmd_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    qry_write_s |-> flash_addr == (s_r.bm ? query_host_pkg::ADR_QUERY_B
                                          : query_host_pkg::ADR_QUERY_W))
    else $error("query command at wrong address");

  word_high_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    (!flash_oe_n && !s_r.bm) |-> flash_addr[19:7] == 13'h0000)
    else $error("word read with high address bits set");

  byte_double_a: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
    (!flash_oe_n && s_r.bm) |-> flash_addr == {13'h0000, s_r.idx, 1'b0})
    else $error("byte read address not doubled");

  no_drive_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    !flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("bus contention during read");

  reset_after_tbl_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    (s_r.st == S_NEXT && s_r.ph == P_TBL && s_r.idx == query_host_pkg::TBL_LAST)
      |=> s_r.ph == P_RST)
    else $error("no reset after table walk");

  auto_two_resets_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    (s_r.st == S_NEXT && s_r.ph == P_RST && s_r.au) |=> s_r.ph == P_RST2 && s_r.st == S_WR)
    else $error("autoselect exit lacks second reset");

  unlock_order_a: assert property (@(posedge clk) disable iff (!rst_n) // [R23]
    (s_r.st == S_NEXT && s_r.ph == P_UNL1) |=> s_r.ph == P_UNL2 ##0 s_r.st == S_WR)
    else $error("unlock order broken");

  start_autosel_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (s_r.st == S_IDLE && start && via_autosel) |=> s_r.ph == P_UNL1 && s_r.au)
    else $error("autoselect path not taken");

  reset_any_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // [R22]
    (!flash_we_n && flash_dq_out[7:0] == query_host_pkg::CMD_RESET)
      |-> flash_addr == query_host_pkg::ADR_RESET)
    else $error("reset command address");
endmodule

// ---- dv/flash_query_model.sv ----
`timescale 1ns/10ps
// Behavioural flash: command decode and query table
module flash_query_model (
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_byte_n,
  input  wire logic [19:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        slow,
  input  wire logic [5:0]  bad_idx,
  input  wire logic [15:0] corrupt,
  output logic      [15:0] flash_dq_in,
  output logic      [1:0]  mode,
  output int               reads,
  output logic             back_auto
);
  logic [1:0]  unl;
  logic        from_auto;
  logic        ok;
  logic [5:0]  idx;
  logic [15:0] q;
  logic [15:0] rd;
  logic [15:0] last;
  logic [7:0]  c;
  logic [19:0] a;
  initial begin
    mode = 2'h0;
    unl = 2'h0;
    reads = 0;
    back_auto = 1'b0;
    last = 16'h0000;
    flash_dq_in = 16'hFFFF;
  end
  assign idx = flash_byte_n ? flash_addr[5:0] : flash_addr[6:1];
  assign ok = flash_byte_n ? (flash_addr[19:7] == 13'h0000) : !flash_addr[0];
  always_comb begin
    case (idx)
      6'h10: q = 16'h0051;
      6'h11: q = 16'h0052;
      6'h12: q = 16'h0059;
      6'h13: q = 16'h0002;
      6'h15: q = 16'h0040;
      6'h1B: q = 16'h0017;
      6'h1C: q = 16'h0019;
      6'h1F: q = 16'h0003;
      6'h21: q = 16'h0009;
      6'h23: q = 16'h0005;
      6'h25: q = 16'h0004;
      6'h27: q = 16'h0015;
      6'h28: q = 16'h0002;
      6'h2C: q = 16'h0002;
      6'h2D: q = 16'h0007;
      6'h2F: q = 16'h0020;
      6'h31: q = 16'h001E;
      6'h34: q = 16'h0001;
      default: q = 16'h0000;
    endcase
  end
  assign rd = (mode == 2'h2 && ok) ? q ^ ((idx == bad_idx) ? corrupt : 16'h0000) : ~last;
  // Released bus shows inverse of last value; byte mode drives upper lane with inverse of last upper byte
  always @(flash_ce_n, flash_oe_n, flash_addr, mode) begin
    flash_dq_in = ~last;
    if (!flash_ce_n && !flash_oe_n) begin
      #(slow ? 70 : 6);
      flash_dq_in = flash_byte_n ? rd : {~last[15:8], rd[7:0]};
      last = flash_dq_in;
    end
  end
  always @(negedge flash_oe_n) begin
    // Chip enable falls in the same step
    #1;
    if (!flash_ce_n && mode == 2'h2) begin
      reads = reads + 1;
    end
  end
  always @(posedge flash_we_n) begin
    if (!flash_ce_n) begin
      c = flash_dq_out[7:0];
      a = flash_addr;
      if (c == query_host_pkg::CMD_RESET) begin
        back_auto = back_auto | (mode == 2'h2 && from_auto);
        mode = (mode == 2'h2 && from_auto) ? 2'h1 : 2'h0;
        unl = 2'h0;
      end else if (c == query_host_pkg::CMD_QUERY && mode != 2'h2 && a == (flash_byte_n ?
          query_host_pkg::ADR_QUERY_W : query_host_pkg::ADR_QUERY_B)) begin
        from_auto = (mode == 2'h1);
        back_auto = 1'b0;
        mode = 2'h2;
      end else if (mode == 2'h0 && unl == 2'h0 && c == query_host_pkg::CMD_UNLOCK1 && a ==
          (flash_byte_n ? query_host_pkg::ADR_UNLOCK1_W : query_host_pkg::ADR_UNLOCK1_B)) begin
        unl = 2'h1;
      end else if (mode == 2'h0 && unl == 2'h1 && c == query_host_pkg::CMD_UNLOCK2 && a ==
          (flash_byte_n ? query_host_pkg::ADR_UNLOCK2_W : query_host_pkg::ADR_UNLOCK2_B)) begin
        unl = 2'h2;
      end else if (unl == 2'h2 && c == query_host_pkg::CMD_AUTOSEL) begin
        mode = 2'h1;
        unl = 2'h0;
      end else begin
        unl = 2'h0;
        mode = (mode == 2'h2) ? 2'h2 : 2'h0;
      end
    end
  end
endmodule

// ---- dv/query_host_tb.sv ----
`timescale 1ns/10ps
module query_host_tb;
  logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, byte_mode = 1'b0, via_autosel = 1'b0;
  logic slow = 1'b0, busy, done, match, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  logic flash_byte_n, back_auto;
  logic [5:0]  fail_idx, bad_idx = 6'h00;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in, corrupt = 16'h0000;
  logic [1:0]  mode;
  int          reads, miscompares = 0, checked = 0, cycles = 0, dones = 0;
  always #4 clk = ~clk;
  query_host query_host_inst (.clk(clk), .rst_n(rst_n), .start(start), .byte_mode(byte_mode),
    .via_autosel(via_autosel), .busy(busy), .done(done), .match(match), .fail_idx(fail_idx),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_byte_n(flash_byte_n));
  flash_query_model flash_query_model_inst (.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_byte_n(flash_byte_n), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .slow(slow), .bad_idx(bad_idx), .corrupt(corrupt),
    .flash_dq_in(flash_dq_in), .mode(mode), .reads(reads), .back_auto(back_auto));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    dones <= dones + (done === 1'b1 ? 1 : 0);
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One complete table walk; optional second start while busy
  task automatic run(input logic bm, au, sl, again, input logic [5:0] bi,
                     input logic [15:0] cx);
    int n;
    int r0;
    n = 0;
    dones = 0;
    r0 = reads;
    @(posedge clk);
    byte_mode <= bm;
    via_autosel <= au;
    slow <= sl;
    bad_idx <= bi;
    corrupt <= cx;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    if (again) begin
      repeat (50) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
    end
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 4000);
    repeat (3) @(negedge clk);
    check("done count", 16'(dones), 16'h0001);
    check("busy", {15'h0000, busy}, 16'h0000);
    check("query reads", 16'(reads - r0), 16'h002D);
    check("exit mode", {14'h0000, mode}, 16'h0000);
  endtask
  task automatic t_word_array();
    run(1'b0, 1'b0, 1'b0, 1'b0, 6'h00, 16'h0000);
    check("match", {15'h0000, match}, 16'h0001);
    check("fail_idx", {10'h000, fail_idx}, 16'h0000);
    check("back to autoselect", {15'h0000, back_auto}, 16'h0000);
    $display("test word_array done");
  endtask
  task automatic t_byte_array();
    run(1'b1, 1'b0, 1'b0, 1'b0, 6'h00, 16'h0000);
    check("match", {15'h0000, match}, 16'h0001);
    $display("test byte_array done");
  endtask
  task automatic t_auto(input logic bm, input logic sl);
    run(bm, 1'b1, sl, 1'b0, 6'h00, 16'h0000);
    check("match", {15'h0000, match}, 16'h0001);
    check("back to autoselect", {15'h0000, back_auto}, 16'h0001);
    $display("test autoselect done");
  endtask
  task automatic t_word_bad_last();
    run(1'b0, 1'b0, 1'b0, 1'b1, 6'h3C, 16'h0100);
    check("match", {15'h0000, match}, 16'h0000);
    check("fail_idx", {10'h000, fail_idx}, 16'h003C);
    $display("test word_bad_last done");
  endtask
  task automatic t_byte_bad_first();
    run(1'b1, 1'b0, 1'b0, 1'b0, 6'h10, 16'h0001);
    check("fail_idx", {10'h000, fail_idx}, 16'h0010);
    $display("test byte_bad_first done");
  endtask
  task automatic t_reset_mid();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (100) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    check("busy in reset", {15'h0000, busy}, 16'h0000);
    check("ce_n in reset", {15'h0000, flash_ce_n}, 16'h0001);
    check("dq_oe in reset", {15'h0000, flash_dq_oe}, 16'h0000);
    check("oe_n in reset", {15'h0000, flash_oe_n}, 16'h0001);
    check("we_n in reset", {15'h0000, flash_we_n}, 16'h0001);
    check("match in reset", {15'h0000, match}, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    run(1'b0, 1'b0, 1'b0, 1'b0, 6'h00, 16'h0000);
    check("match after reset", {15'h0000, match}, 16'h0001);
    $display("test reset_mid done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_word_array();
    t_byte_array();
    t_auto(1'b0, 1'b1);
    t_auto(1'b1, 1'b0);
    t_word_bad_last();
    t_byte_bad_first();
    t_reset_mid();
    final_report();
  end
endmodule
